/* hgc_pkg.sv */
// Package of offsets, field positions and constants for the group configuration bank
package hgc_pkg;
  // Register offsets within the group structure
  localparam logic [11:0] OFF_GLOBAL_CFG = 12'h600;
  localparam logic [11:0] OFF_IRQ_BASE = 12'h604;
  localparam logic [11:0] OFF_IRQ_SIZE = 12'h608;
  localparam logic [11:0] OFF_GROUP_CFG = 12'h60C;
  localparam logic [11:0] OFF_MEM_PROT = 12'h610;
  // Host-side controller registers
  localparam logic [3:0] HOFF_CMD = 4'h0;
  localparam logic [3:0] HOFF_ADDR = 4'h4;
  localparam logic [3:0] HOFF_WDATA = 4'h8;
  localparam logic [3:0] HOFF_STATUS = 4'hC;
  localparam logic [3:0] HOFF_RDATA = 4'h2;
  localparam int ADDR_W = 12;
  // Global configuration field positions
  localparam int GC_TXACT_LSB = 0;
  localparam int GC_RXACT_LSB = 4;
  localparam int GC_LAPSE_B_LSB = 8;
  localparam int GC_ECK_BIT = 11;
  localparam int GC_MPU_BIT = 12;
  localparam int GC_LAPSE_A_LSB = 13;
  localparam int GC_LAPSE_E_LSB = 16;
  localparam int GC_PMAP_LSB = 19;
  localparam logic [31:0] GC_RO_MASK = 32'h000000FF;
  localparam logic [31:0] GC_RW_MASK = 32'h001FFF00;
  // Group configuration field positions
  localparam int GR_RXON_BIT = 0;
  localparam int GR_TXON_BIT = 1;
  localparam int GR_SUBOFF_BIT = 2;
  localparam int GR_FRAME_LOSS_ABORT_BIT = 3;
  localparam int GR_FRAME_LOSS_IRQ_MASK_BIT = 4;
  localparam int GR_ALIGN_CHANGE_IRQ_MASK_BIT = 5;
  localparam int GR_MCCOPY_BIT = 6;
  localparam int GR_PVA_BIT = 7;
  localparam int GR_RXINH_BIT = 8;
  localparam int GR_TXINH_BIT = 9;
  localparam int GR_POLL_LSB = 10;
  localparam int GR_SFA_LSB = 12;
  localparam int GR_SIGNAL_UNIT_ERR_THRESHOLD_LSB = 14;
  localparam logic [31:0] GR_RW_MASK = 32'h0000FFFF;
  localparam int MP_GUARD_BIT = 0;
  // Queue size limits, zero based
  localparam logic [14:0] IQ_SIZE_MAX_M1 = 15'h7FFF;
  localparam logic [14:0] IQ_SIZE_MIN_M1 = 15'h0001;
  localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] RESET_ZERO = 32'h00000000;
  // Clock activity timeout in mclk cycles
  localparam int CLK_SEEN_WINDOW = 64;
  localparam logic [1:0] POLL_EVERY_16 = 2'h1;
  localparam logic [3:0] POLL_DIV_MAX = 4'hF;
endpackage

/* hgc_if.sv */
// Interface joining host controller and device register bank
`timescale 1ns/1ps
`default_nettype none
interface hgc_if;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic srv;
  logic [31:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, input srv, output rdata);
  modport host (output addr, output wdata, output wr, output rd, output srv, input rdata);
endinterface
`default_nettype wire

/* hgc_host_ctrl.sv */
// Host-side controller issuing register writes and reads to the bank
`timescale 1ns/1ps
`default_nettype none
module hgc_host_ctrl
  import hgc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic chanActive,
  hgc_if.host bus
);
  logic [31:0] cmdQ, addrQ, wdataQ, rdataQ, outQ;
  logic busyQ, rdPendQ, rdCapQ, blockedQ;
  logic [11:0] aQ;
  logic [31:0] wQ;
  logic wrQ, rdQ, srvQ;
  // Software command registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmdQ <= RESET_ZERO;
      addrQ <= RESET_ZERO;
      wdataQ <= RESET_ZERO;
    end else if (regWr) begin
      case (regAddr)
        HOFF_CMD: cmdQ <= regWdata;
        HOFF_ADDR: addrQ <= regWdata;
        HOFF_WDATA: wdataQ <= regWdata;
        default: ;
      endcase
    end
  end
  // Issue one device access per command; direct access refused when active
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrQ <= 1'b0;
      rdQ <= 1'b0;
      srvQ <= 1'b0;
      aQ <= 12'h000;
      wQ <= RESET_ZERO;
      busyQ <= 1'b0;
      blockedQ <= 1'b0;
    end else begin
      wrQ <= 1'b0;
      rdQ <= 1'b0;
      srvQ <= 1'b0;
      busyQ <= 1'b0;
      if (regWr && regAddr == HOFF_CMD && regWdata[1:0] != 2'h0) begin
        // Direct writes barred once channels run; service path stays open
        blockedQ <= chanActive && !regWdata[2];
        if (!(chanActive && !regWdata[2])) begin
          aQ <= addrQ[11:0] & 12'hFFC; // Word aligned access
          wQ <= wdataQ;
          wrQ <= regWdata[0];
          rdQ <= regWdata[1] & ~regWdata[0];
          srvQ <= regWdata[2];
          busyQ <= 1'b1;
        end
      end
    end
  end
  // Capture device read data one cycle after the read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdPendQ <= 1'b0;
      rdCapQ <= 1'b0;
      rdataQ <= RESET_ZERO;
    end else begin
      rdPendQ <= rdQ;
      rdCapQ <= rdPendQ;
      if (rdPendQ) rdataQ <= bus.rdata;
    end
  end
  // Software read port, data one cycle after strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) outQ <= RESET_ZERO;
    else if (regRd) begin
      case (regAddr)
        HOFF_CMD: outQ <= cmdQ;
        HOFF_ADDR: outQ <= addrQ;
        HOFF_WDATA: outQ <= wdataQ;
        HOFF_STATUS: outQ <= {28'h0000000, blockedQ, rdCapQ, rdPendQ, busyQ};
        HOFF_RDATA: outQ <= rdataQ;
        default: outQ <= ALL_ONES;
      endcase
    end
  end
  assign regRdata = outQ;
  assign bus.addr = aQ;
  assign bus.wdata = wQ;
  assign bus.wr = wrQ;
  assign bus.rd = rdQ;
  assign bus.srv = srvQ;
endmodule
`default_nettype wire

/* hgc_group_regs.sv */
// Device-side configuration descriptor bank for one channel group
//
// Function
// - Clock-activity flags read-only, writes ignored
// - Expansion clock output off when field zero
// - Field zero selects first handshake protocol
// - Map zero connects port n to group n
// - Bank aligns queue pointer to four bytes
// - Queue length field is entries minus one
// - Queue holds 2 to 32768 word entries
// - Queue descriptor written as two words
// - Accept direct writes or service fetches
// - Zero threshold disables SS7 error monitoring
// - Alignment zero keeps internal flywheel
// - Throttle one polls every 16th frame
// - Inhibit zero allows status writebacks
// - Action zero resets group on violation
// - Copy one copies message configuration bits
// - Mask zero reports alignment/frame-loss interrupts
// - Abort zero continues after frame loss
// - Disable zero allows subchannel mapping
// - Enables turn transmitter/receiver on
// - Guard zero disables address range checks
// - Unmapped reads all ones, writes ignored
// - Host uses service requests once active
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hgc_group_regs
  import hgc_pkg::*;
#(
  parameter int SEEN_WINDOW = CLK_SEEN_WINDOW
) (
  input wire logic mclk,
  input wire logic rst_n,
  hgc_if.dev bus,
  input wire logic [3:0] txLineClk,
  input wire logic [3:0] rxLineClk,
  input wire logic frameTick,
  input wire logic protViolation,
  input wire logic alignChangeEvt,
  input wire logic frameLossEvt,
  output logic expbusClockOutOn,
  output logic hostBusStyleSel,
  output logic [7:0] portGroupSel,
  output logic [31:0] irqQueueBase,
  output logic [14:0] irqQueueEntriesM1,
  output logic groupTxOn,
  output logic groupRxOn,
  output logic subchannelOn,
  output logic frameLossAbort,
  output logic alignChangeIrq,
  output logic frameLossIrq,
  output logic msgCfgCopyOn,
  output logic groupResetReq,
  output logic txStatusWriteOn,
  output logic rxStatusWriteOn,
  output logic pollNow,
  output logic flywheelOn,
  output logic ss7MonitorOn,
  output logic addressGuardOn
);
  logic [31:0] globalQ, iqBaseQ, iqSizeQ, groupQ, protQ, rdataQ;
  logic [3:0] txPrevQ, rxPrevQ;
  logic [7:0] seenQ;
  logic [7:0][6:0] cntQ;
  logic [3:0] pollCntQ;
  logic pollQ, cofaQ, oofQ, resetQ;
  logic [31:0] wrVal;
  logic [7:0] lineEdge, portSelQ;
  logic subOnQ, txWbQ, rxWbQ, flyQ, ss7Q;

  // Service requests and direct writes share one path
  assign wrVal = bus.wdata;

  // Clamp a zero-based queue size to the legal range
  function automatic logic [14:0] clampSize(input logic [31:0] v);
    if (v[31:15] != 17'h00000) clampSize = IQ_SIZE_MAX_M1;
    else if (v[14:0] < IQ_SIZE_MIN_M1) clampSize = IQ_SIZE_MIN_M1;
    else clampSize = v[14:0];
  endfunction

  // Descriptor registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      globalQ <= RESET_ZERO;
      iqBaseQ <= RESET_ZERO;
      iqSizeQ <= RESET_ZERO;
      groupQ <= RESET_ZERO;
      protQ <= RESET_ZERO;
    end else if (bus.wr || bus.srv) begin
      case (bus.addr)
        // Flags masked off, lapse fields kept as written
        OFF_GLOBAL_CFG: globalQ <= wrVal & GC_RW_MASK;
        OFF_IRQ_BASE: iqBaseQ <= {wrVal[31:2], 2'b00};
        OFF_IRQ_SIZE: iqSizeQ <= {17'h00000, clampSize(wrVal)};
        OFF_GROUP_CFG: groupQ <= wrVal & GR_RW_MASK;
        OFF_MEM_PROT: protQ <= {31'h00000000, wrVal[MP_GUARD_BIT]};
        default: ; // Unmapped write ignored
      endcase
    end
  end

  // Toggle on any line clock since last cycle, tx in low nibble
  assign lineEdge = {rxLineClk ^ rxPrevQ, txLineClk ^ txPrevQ};

  // Line clock activity: edge seen within a window
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txPrevQ <= 4'h0;
      rxPrevQ <= 4'h0;
      cntQ <= '0;
      seenQ <= 8'h00;
    end else begin
      txPrevQ <= txLineClk;
      rxPrevQ <= rxLineClk;
      for (int i = 0; i < 8; i++) begin
        if (lineEdge[i]) begin
          cntQ[i] <= 7'(SEEN_WINDOW);
          seenQ[i] <= 1'b1;
        end else if (cntQ[i] != 7'h00) begin
          cntQ[i] <= cntQ[i] - 7'h01;
        end else begin
          seenQ[i] <= 1'b0;
        end
      end
    end
  end

  // Register read, all ones for unmapped offsets
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rdataQ <= RESET_ZERO;
    else if (bus.rd) begin
      case (bus.addr)
        OFF_GLOBAL_CFG: rdataQ <= globalQ | {24'h000000, seenQ};
        OFF_IRQ_BASE: rdataQ <= iqBaseQ;
        OFF_IRQ_SIZE: rdataQ <= iqSizeQ;
        OFF_GROUP_CFG: rdataQ <= groupQ;
        OFF_MEM_PROT: rdataQ <= protQ;
        default: rdataQ <= ALL_ONES;
      endcase
    end
  end
  assign bus.rdata = rdataQ;

  // Buffer ownership polling, every 16th frame when throttled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pollCntQ <= 4'h0;
      pollQ <= 1'b0;
    end else begin
      pollQ <= 1'b0;
      if (frameTick) begin
        pollCntQ <= (pollCntQ == POLL_DIV_MAX) ? 4'h0 : pollCntQ + 4'h1;
        if (groupQ[GR_POLL_LSB +: 2] != POLL_EVERY_16 || pollCntQ == 4'h0) pollQ <= 1'b1;
      end
    end
  end

  // Event gating: interrupts, violation reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cofaQ <= 1'b0;
      oofQ <= 1'b0;
      resetQ <= 1'b0;
    end else begin
      cofaQ <= alignChangeEvt & ~groupQ[GR_ALIGN_CHANGE_IRQ_MASK_BIT];
      oofQ <= frameLossEvt & ~groupQ[GR_FRAME_LOSS_IRQ_MASK_BIT];
      // Reset only when guard on and action zero
      resetQ <= protViolation & protQ[MP_GUARD_BIT] & ~groupQ[GR_PVA_BIT];
    end
  end

  // Decoded configuration outputs, one flop each so no logic follows
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      portSelQ <= 8'hE4;
      subOnQ <= 1'b1;
      txWbQ <= 1'b1;
      rxWbQ <= 1'b1;
      flyQ <= 1'b1;
      ss7Q <= 1'b0;
    end else begin
      portSelQ <= (globalQ[GC_PMAP_LSB +: 2] == 2'h0) ? 8'hE4
                : {globalQ[GC_PMAP_LSB +: 2], 6'h00};
      subOnQ <= ~groupQ[GR_SUBOFF_BIT];
      txWbQ <= ~groupQ[GR_TXINH_BIT];
      rxWbQ <= ~groupQ[GR_RXINH_BIT];
      flyQ <= (groupQ[GR_SFA_LSB +: 2] == 2'h0);
      ss7Q <= (groupQ[GR_SIGNAL_UNIT_ERR_THRESHOLD_LSB +: 2] != 2'h0);
    end
  end

  // Configuration outputs straight from registers
  assign expbusClockOutOn = globalQ[GC_ECK_BIT];
  assign hostBusStyleSel = globalQ[GC_MPU_BIT];
  assign portGroupSel = portSelQ;
  assign irqQueueBase = iqBaseQ;
  assign irqQueueEntriesM1 = iqSizeQ[14:0];
  assign groupTxOn = groupQ[GR_TXON_BIT];
  assign groupRxOn = groupQ[GR_RXON_BIT];
  assign subchannelOn = subOnQ;
  assign frameLossAbort = groupQ[GR_FRAME_LOSS_ABORT_BIT];
  assign alignChangeIrq = cofaQ;
  assign frameLossIrq = oofQ;
  assign msgCfgCopyOn = groupQ[GR_MCCOPY_BIT];
  assign groupResetReq = resetQ;
  assign txStatusWriteOn = txWbQ;
  assign rxStatusWriteOn = rxWbQ;
  assign pollNow = pollQ;
  assign flywheelOn = flyQ;
  assign ss7MonitorOn = ss7Q;
  assign addressGuardOn = protQ[MP_GUARD_BIT];
endmodule
`default_nettype wire

/* hgc_monitor.sv */
// Checker of the bus between host controller and register bank
`timescale 1ns/1ps
`default_nettype none
module hgc_monitor
  import hgc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic srv,
  input wire logic [31:0] rdata
);
  logic put;
  logic known;
  logic [31:0] gcQ, grpQ, baseQ;
  logic [14:0] sizeQ;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Any accepted write, direct or fetched
  assign put = wr | srv;
  assign known = addr inside {OFF_GLOBAL_CFG, OFF_IRQ_BASE, OFF_IRQ_SIZE, OFF_GROUP_CFG,
    OFF_MEM_PROT};
  // Shadow copies of what the bank should hold
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gcQ <= '0;
      grpQ <= '0;
      baseQ <= '0;
      sizeQ <= '0;
    end else if (put) begin
      if (addr == OFF_GLOBAL_CFG) gcQ <= wdata & GC_RW_MASK;
      if (addr == OFF_GROUP_CFG) grpQ <= wdata & GR_RW_MASK;
      if (addr == OFF_IRQ_BASE) baseQ <= {wdata[31:2], 2'h0};
      if (addr == OFF_IRQ_SIZE) sizeQ <= (|wdata[31:15]) ? IQ_SIZE_MAX_M1 :
        ((wdata[14:0] == 15'h0) ? IQ_SIZE_MIN_M1 : wdata[14:0]);
    end
  end
  property p_unmapped; rd && !known |=> rdata == ALL_ONES; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not all ones");
  property p_hold; !rd |=> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_one; !(rd && put); endproperty
  a_one: assert property (p_one) else $error("read and write together");
  property p_pulse; put |=> !put; endproperty
  a_pulse: assert property (p_pulse) else $error("write strobe longer than a cycle");
  property p_gc; rd && addr == OFF_GLOBAL_CFG |=> (rdata & ~GC_RO_MASK) == gcQ; endproperty
  a_gc: assert property (p_gc) else $error("global word readback wrong");
  property p_grp; rd && addr == OFF_GROUP_CFG |=> rdata == grpQ; endproperty
  a_grp: assert property (p_grp) else $error("group word readback wrong");
  property p_base; rd && addr == OFF_IRQ_BASE |=> rdata == baseQ; endproperty
  a_base: assert property (p_base) else $error("queue base not word aligned");
  property p_size; rd && addr == OFF_IRQ_SIZE |=> rdata == {17'h0, sizeQ}; endproperty
  a_size: assert property (p_size) else $error("queue size readback wrong");
  c_srv: cover property (srv);
  c_unm: cover property (rd && !known);
  c_grp: cover property (rd && addr == OFF_GROUP_CFG);
endmodule
`default_nettype wire

/* tb_top.sv */
// Testbench joining host controller and register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import hgc_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic chanActive = 1'b0;
  logic frameTick = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [7:0] lineClk = 8'h00;
  logic [7:0] clkRun = 8'h00;
  logic [31:0] regRdata, iqBase;
  logic [7:0] pgSel;
  logic [14:0] iqM1;
  logic expOn, styleSel, txOn, rxOn, subOn, frame_loss_abort, cofaIrq, oofIrq, mcOn, grpRst;
  logic txWb, rxWb, pollNow, flyOn, ss7On, guardOn;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int pollCnt = 0;
  int p0;
  logic [31:0] szIn [4] = '{32'h9, 32'h0, 32'h10000, 32'h7FFF};
  logic [31:0] szExp [4] = '{32'h9, 32'h1, 32'h7FFF, 32'h7FFF};
  hgc_if hgc_if_i ();
  hgc_host_ctrl hgc_host_ctrl_i (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .chanActive(chanActive), .bus(hgc_if_i));
  hgc_group_regs #(.SEEN_WINDOW(8)) hgc_group_regs_i (.mclk(mclk), .rst_n(rst_n),
    .bus(hgc_if_i), .txLineClk(lineClk[3:0]), .rxLineClk(lineClk[7:4]),
    .frameTick(frameTick), .protViolation(ev[2]), .alignChangeEvt(ev[1]),
    .frameLossEvt(ev[0]), .expbusClockOutOn(expOn), .hostBusStyleSel(styleSel),
    .portGroupSel(pgSel), .irqQueueBase(iqBase), .irqQueueEntriesM1(iqM1),
    .groupTxOn(txOn), .groupRxOn(rxOn), .subchannelOn(subOn), .frameLossAbort(frame_loss_abort),
    .alignChangeIrq(cofaIrq), .frameLossIrq(oofIrq), .msgCfgCopyOn(mcOn),
    .groupResetReq(grpRst), .txStatusWriteOn(txWb), .rxStatusWriteOn(rxWb),
    .pollNow(pollNow), .flywheelOn(flyOn), .ss7MonitorOn(ss7On), .addressGuardOn(guardOn));
  hgc_monitor hgc_monitor_i (.mclk(mclk), .rst_n(rst_n), .addr(hgc_if_i.addr),
    .wdata(hgc_if_i.wdata), .wr(hgc_if_i.wr), .rd(hgc_if_i.rd), .srv(hgc_if_i.srv),
    .rdata(hgc_if_i.rdata));
  // Clock, line clocks, poll counting and hang guard
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    lineClk <= lineClk ^ clkRun;
    if (pollNow === 1'b1) pollCnt <= pollCnt + 1;
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("FAIL %0t got %h want %h", $time, got, exp);
      err_total++;
    end
  endtask
  // Host controller register write and read
  task automatic hw(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic hr(input logic [3:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
  endtask
  // One bank access through the controller
  task automatic dev(input logic [2:0] c, input logic [11:0] a, input logic [31:0] d);
    hw(HOFF_ADDR, {20'h0, a});
    hw(HOFF_WDATA, d);
    hw(HOFF_CMD, {29'h0, c});
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic evt(input logic [2:0] v, input logic [2:0] e);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= 3'h0;
    #1;
    chk({29'h0, grpRst, cofaIrq, oofIrq}, {29'h0, e});
  endtask
  // Frame ticks one cycle wide, then let the last poll pulse be counted
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      frameTick <= 1'b1;
      @(posedge mclk);
      frameTick <= 1'b0;
    end
    repeat (3) @(posedge mclk);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk({20'h0, pgSel, subOn, flyOn, txWb, rxWb}, 32'h00000E4F);
    chk({27'h0, expOn, styleSel, ss7On, guardOn, txOn}, 32'h0);
    $display("reset test done");
    clkRun <= 8'h21;
    repeat (20) @(posedge mclk);
    dev(3'h1, OFF_GLOBAL_CFG, ALL_ONES);
    dev(3'h2, OFF_GLOBAL_CFG, 32'h0);
    chk(hgc_if_i.rdata, GC_RW_MASK | 32'h21);
    chk({30'h0, expOn, styleSel}, 32'h3);
    @(posedge mclk);
    clkRun <= 8'h00;
    dev(3'h5, OFF_GLOBAL_CFG, 32'h0);
    repeat (12) @(posedge mclk);
    dev(3'h2, OFF_GLOBAL_CFG, 32'h0);
    chk(hgc_if_i.rdata, 32'h0);
    chk({30'h0, expOn, styleSel}, 32'h0);
    $display("global test done");
    dev(3'h1, OFF_IRQ_BASE, 32'h12345677);
    dev(3'h2, OFF_IRQ_BASE, 32'h0);
    chk(hgc_if_i.rdata, 32'h12345674);
    chk(iqBase, 32'h12345674);
    hr(HOFF_RDATA);
    chk(regRdata, 32'h12345674);
    hr(4'h3);
    chk(regRdata, ALL_ONES);
    for (int i = 0; i < 4; i++) begin
      dev(3'h1, OFF_IRQ_SIZE, szIn[i]);
      dev(3'h2, OFF_IRQ_SIZE, 32'h0);
      chk(hgc_if_i.rdata, szExp[i]);
      chk({17'h0, iqM1}, szExp[i]);
    end
    $display("queue test done");
    dev(3'h1, OFF_GROUP_CFG, 32'h443);
    dev(3'h1, OFF_MEM_PROT, 32'h1);
    chk({26'h0, txOn, rxOn, mcOn, subOn, frame_loss_abort, guardOn}, 32'h3D);
    evt(3'h7, 3'h7);
    p0 = pollCnt;
    ticks(32);
    chk(pollCnt - p0, 32'h2);
    dev(3'h1, OFF_GROUP_CFG, ALL_ONES);
    dev(3'h2, OFF_GROUP_CFG, 32'h0);
    chk(hgc_if_i.rdata, 32'h0000FFFF);
    chk({26'h0, subOn, txWb, rxWb, flyOn, ss7On, frame_loss_abort}, 32'h3);
    evt(3'h7, 3'h0);
    p0 = pollCnt;
    ticks(4);
    chk(pollCnt - p0, 32'h4);
    $display("group test done");
    dev(3'h1, 12'h700, 32'h5A);
    dev(3'h2, 12'h700, 32'h0);
    chk(hgc_if_i.rdata, ALL_ONES);
    @(posedge mclk);
    chanActive <= 1'b1;
    dev(3'h1, OFF_GROUP_CFG, 32'h0);
    hr(HOFF_STATUS);
    chk({31'h0, regRdata[3]}, 32'h1);
    chk({31'h0, txOn}, 32'h1);
    dev(3'h5, OFF_GROUP_CFG, 32'h0);
    chk({31'h0, txOn}, 32'h0);
    $display("access test done");
    finish_test();
  end
endmodule
`default_nettype wire
